// ===== logic/isc_status_ctrl.sv
// instruction stage status flags, instruction class encoders and apb registers
`timescale 1ns/1ps
`default_nettype none
module isc_status_ctrl (
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // register bus
    input  wire isc_pkg::isc_apb_req_t         apb_req,
    output isc_pkg::isc_apb_rsp_t              apb_rsp,
    // sequence events from the control unit
    input  wire isc_pkg::isc_seq_in_t          seq_in,
    // instruction in the second instruction register
    input  wire isc_pkg::isc_instr_t           second_instr,
    // stage flags
    output isc_pkg::isc_stage_t                stage,
    // chain use during operand select
    output isc_pkg::isc_chain_t                chain_use,
    output logic [2:0]                         a_input_uses,
    output logic [1:0]                         result_uses,
    output logic [1:0]                         mem_refs,
    // encoder outputs
    output logic [isc_pkg::GROUP_W-1:0]        control_group,
    output logic [3:0]                         arith_group,
    output logic [isc_pkg::PROG_W-1:0]         program_stage_line,
    // direct transfers
    output logic                               shift_digits_transfer,
    output logic [7:0]                         arith_shift_register,
    output logic                               selector_direct_load,
    output logic [isc_pkg::A_PART_W-1:0]       fast_reg_selector
);
    import isc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state of the block
    typedef struct packed {
        isc_stage_t          stg;
        logic [PHASE_W-1:0]  epd_cnt;
        isc_class_t          cls;
        isc_chain_t          chain;
        logic [2:0]          a_uses;
        logic [1:0]          r_uses;
        logic [1:0]          m_refs;
        logic [GROUP_W-1:0]  ctl_grp;
        logic [3:0]          ar_grp;
        logic [PROG_W-1:0]   prog;
        logic [CNT_W-1:0]    opsel_cnt;
        logic [CNT_W-1:0]    opsel_last;
        logic [7:0]          shift_digits;
        logic [A_PART_W-1:0] fr_select;
        logic                shift_xfer;
        logic                sel_load;
        logic                soft_clr;
        isc_apb_rsp_t        rsp;
    } isc_core_t;

    isc_core_t   st_ff;
    isc_core_t   nxt_st;
    isc_timing_t tim;

    ////////////////////////////////////////////////////////////////////////////
    // control-unit encoder: opcode to instruction class
    function automatic isc_class_t ctl_class(input logic [7:0] op);
        isc_class_t c;
        c = CLS_NONE;
        if (op inside {[8'h01:8'h06], 8'h11, 8'h12, [8'h14:8'h16],
                       [8'h20:8'h27], [8'h30:8'h32], [8'h34:8'h37]}) begin
            c = CLS_ARITH;
        end else if (op inside {[8'h60:8'h64]}) begin
            c = CLS_EXTR;
        end else if (op inside {8'h65, 8'h66}) begin
            c = CLS_EXTR_LU;
        end else if (op inside {[8'h50:8'h53]}) begin
            c = CLS_SHIFT_S;
        end else if (op inside {[8'h55:8'h59]}) begin
            c = CLS_SHIFT_D;
        end else if (op inside {8'h43, 8'h48}) begin
            c = CLS_FETCH;
        end else if (op inside {[8'h40:8'h42], [8'h45:8'h47]}) begin
            c = CLS_STORE;
        end else if (op == 8'h93) begin
            c = CLS_SLJ;
        end else if (op == 8'h92) begin
            c = CLS_UJUMP;
        end else if (op inside {8'h70, 8'h71, 8'h75, 8'h76}) begin
            c = CLS_COMP_AM;
        end else if (op inside {[8'h72:8'h74]}) begin
            c = CLS_COMP_M;
        end else if (op inside {[8'h80:8'h83], 8'h85, 8'h86}) begin
            c = CLS_INDEX;
        end else if (op inside {8'h09, 8'h19}) begin
            c = CLS_VIS_IN;
        end else if (op inside {8'h29, 8'h39}) begin
            c = CLS_VIS_OUT;
        end
        return c;
    endfunction

    // chain and operand use of each class
    function automatic isc_chain_t chain_of(input isc_class_t c);
        isc_chain_t ch;
        ch = '0;
        unique case (c)
            CLS_NONE:    ch = '0;
            CLS_ARITH:   ch = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            CLS_EXTR:    ch = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            CLS_EXTR_LU: ch = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            CLS_SHIFT_S: ch = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
            CLS_SHIFT_D: ch = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
            CLS_FETCH:   ch = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            CLS_STORE:   ch = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
            CLS_SLJ:     ch = '0;
            CLS_UJUMP:   ch = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            CLS_COMP_AM: ch = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
            CLS_COMP_M:  ch = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
            CLS_INDEX:   ch = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            CLS_VIS_IN:  ch = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            CLS_VIS_OUT: ch = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            default:     ch = '0;
        endcase
        return ch;
    endfunction

    // arithmetic-unit encoder: groups by arithmetic needs
    function automatic logic [3:0] arith_group_of(input isc_class_t c);
        logic [3:0] g;
        g = 4'h0;
        unique case (c)
            CLS_ARITH, CLS_EXTR, CLS_EXTR_LU:        g = 4'h1;
            CLS_SHIFT_S, CLS_SHIFT_D:                g = 4'h2;
            CLS_COMP_AM, CLS_COMP_M:                 g = 4'h3;
            CLS_FETCH, CLS_STORE, CLS_VIS_IN,
            CLS_VIS_OUT, CLS_SLJ, CLS_UJUMP,
            CLS_INDEX:                               g = 4'h4;
            CLS_NONE:                                g = 4'h0;
            default:                                 g = 4'h0;
        endcase
        return g;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // cycle timing source
    isc_timing_gen u_timing (
        .pclk    (pclk),
        .presetn (presetn),
        .tim     (tim)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic         clr;
        logic         new_opsel;
        logic         setup;
        logic         access;
        logic         dbl;
        isc_class_t   c;
        isc_chain_t   ch;
        clr       = seq_in.general_clear | st_ff.soft_clr;
        new_opsel = st_ff.stg.stage_one_flag & seq_in.no_conflict_inequality;
        setup     = apb_req.psel & ~apb_req.penable;
        access    = apb_req.psel & apb_req.penable & st_ff.rsp.pready;
        c         = ctl_class(second_instr.opcode);
        ch        = chain_of(c);
        dbl       = second_instr.double_precision & (c == CLS_ARITH);
        nxt_st    = st_ff;
        nxt_st.shift_xfer = 1'b0;
        nxt_st.sel_load   = 1'b0;
        nxt_st.soft_clr   = 1'b0;

        // ending-pulse delay lasts exactly one cycle after the pulse
        if (seq_in.instruction_ending_pulse) begin
            nxt_st.epd_cnt = EPD_LOAD;
            nxt_st.stg.epd = 1'b1;
        end else if (st_ff.epd_cnt != '0) begin
            nxt_st.epd_cnt = st_ff.epd_cnt - 1'b1;
        end else begin
            nxt_st.stg.epd = 1'b0;
        end

        // operand-select time counted while stage two is set
        if (st_ff.stg.stage_two_flag) begin
            nxt_st.opsel_cnt = st_ff.opsel_cnt + 1'b1;
        end

        // stage chain steps once per cycle
        if (tim.cycle_start_pulse) begin
            nxt_st.stg.stage_one_flag = seq_in.completing_call |
                (st_ff.stg.stage_one_flag & ~seq_in.no_conflict_inequality);
            nxt_st.stg.stage_two_flag = new_opsel |
                (st_ff.stg.stage_two_flag & ~st_ff.stg.epd);
            nxt_st.stg.stage_three_flag = st_ff.stg.epd;
            nxt_st.stg.stage_four_flag  = st_ff.stg.stage_three_flag &
                ~seq_in.double_first_half;
            if (st_ff.stg.stage_two_flag && !nxt_st.stg.stage_two_flag) begin
                nxt_st.opsel_last = st_ff.opsel_cnt + 1'b1;
            end
            if (new_opsel) begin
                // instruction enters operand select: latch its class
                nxt_st.cls     = c;
                nxt_st.chain   = ch;
                nxt_st.ctl_grp = {1'b0, c};
                nxt_st.ar_grp  = arith_group_of(c);
                nxt_st.prog    = {1'b0, c, 1'b0};
                nxt_st.opsel_cnt = '0;
                nxt_st.a_uses  = ~ch.a_in ? 3'd0 :
                                 ~dbl ? 3'd1 :
                                 second_instr.multiply ? 3'd4 : 3'd2;
                nxt_st.r_uses  = ~ch.res ? 2'd0 : dbl ? 2'd2 : 2'd1;
                nxt_st.m_refs  = ~ch.opm ? 2'd0 : dbl ? 2'd2 : 2'd1;
            end else if (st_ff.stg.stage_two_flag) begin
                nxt_st.prog[0] = 1'b1;
            end
        end

        // chain use is shown only during operand select
        if (!nxt_st.stg.stage_two_flag) begin
            nxt_st.chain  = '0;
            nxt_st.a_uses = '0;
            nxt_st.r_uses = '0;
            nxt_st.m_refs = '0;
        end

        // low m digits go to the arithmetic shift register at pulse five
        if (st_ff.stg.stage_two_flag && st_ff.chain.shift_lsd &&
            tim.timing_pulse[TP_FIVE]) begin
            nxt_st.shift_xfer   = 1'b1;
            nxt_st.shift_digits = second_instr.m_lsd;
        end

        // a part loaded straight into the selector at pulse zero
        if (nxt_st.stg.stage_two_flag && nxt_st.chain.direct_sel &&
            tim.timing_pulse[TP_ZERO]) begin
            nxt_st.sel_load  = 1'b1;
            nxt_st.fr_select = second_instr.a_part;
        end

        // general clear empties the stage chain
        if (clr) begin
            nxt_st.stg     = '0;
            nxt_st.epd_cnt = '0;
            nxt_st.chain   = '0;
            nxt_st.a_uses  = '0;
            nxt_st.r_uses  = '0;
            nxt_st.m_refs  = '0;
        end

        // apb: decode in setup, answer in the first access cycle
        nxt_st.rsp.pready = setup;
        if (setup) begin
            nxt_st.rsp.pslverr = 1'b0;
            nxt_st.rsp.prdata  = RD_RST;
            unique case (apb_req.paddr)
                REG_CTRL:   nxt_st.rsp.prdata = RD_RST;
                REG_STATUS: nxt_st.rsp.prdata = {19'h0_0000, st_ff.cls, 3'b000,
                                                 st_ff.stg};
                REG_OPSEL:  nxt_st.rsp.prdata = {16'h0000, st_ff.opsel_last};
                REG_CHAIN:  nxt_st.rsp.prdata = {18'h0_0000, st_ff.m_refs,
                                                 st_ff.r_uses, st_ff.a_uses,
                                                 st_ff.chain};
                default:    nxt_st.rsp.pslverr = 1'b1;
            endcase
            if (apb_req.pwrite) begin
                nxt_st.rsp.prdata = RD_RST;
            end
        end

        // write to the control register is captured at the access edge; the clear acts one cycle later
        if (access && apb_req.pwrite && !st_ff.rsp.pslverr &&
            apb_req.paddr == REG_CTRL) begin
            nxt_st.soft_clr = apb_req.pwdata[CTRL_CLEAR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign apb_rsp               = st_ff.rsp;
    assign stage                 = st_ff.stg;
    assign chain_use             = st_ff.chain;
    assign a_input_uses          = st_ff.a_uses;
    assign result_uses           = st_ff.r_uses;
    assign mem_refs              = st_ff.m_refs;
    assign control_group         = st_ff.ctl_grp;
    assign arith_group           = st_ff.ar_grp;
    assign program_stage_line    = st_ff.prog;
    assign shift_digits_transfer = st_ff.shift_xfer;
    assign arith_shift_register  = st_ff.shift_digits;
    assign selector_direct_load  = st_ff.sel_load;
    assign fast_reg_selector     = st_ff.fr_select;

endmodule // isc_status_ctrl
`default_nettype wire

// ===== logic/isc_pkg.sv
// constants, types and register map of the instruction stage status control
package isc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and cycle timing
    localparam int CLK_MHZ       = 200;                        // pclk rate
    localparam int CYCLE_TIME_US = 4;                          // basic cycle
    localparam int CYCLE_CYC     = CYCLE_TIME_US * CLK_MHZ;    // pclk per cycle
    localparam int PHASE_W       = 10;
    localparam int TP_COUNT      = 8;                          // numbered pulses
    localparam int TP_STEP       = CYCLE_CYC / TP_COUNT;
    localparam int TP_ZERO       = 0;                          // pulse zero
    localparam int TP_FIVE       = 5;                          // pulse five
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CYCLE_CYC - 1);
    localparam logic [PHASE_W-1:0] PHASE_RST  = '0;

    // ending-pulse delay window
    localparam int EPD_TIME_US = 4;
    localparam int EPD_CYC     = EPD_TIME_US * CLK_MHZ;
    localparam logic [PHASE_W-1:0] EPD_LOAD = PHASE_W'(EPD_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // encoder sizes
    localparam int INSTR_LINES  = 76;
    localparam int CTL_GROUPS   = 49;
    localparam int PROG_LINES   = 90;
    localparam int CS_SHIFT     = 42;                          // chain start, shift digits
    localparam int CS_DIRECT_A  = 3;                           // chain start, direct A
    localparam int CS_DIRECT_B  = 4;
    localparam int GROUP_W      = 6;
    localparam int PROG_W       = 7;
    localparam int A_PART_W     = 20;                          // five digits
    localparam int CNT_W        = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_OPSEL  = 12'h008;
    localparam logic [11:0] REG_CHAIN  = 12'h00C;
    localparam int CTRL_CLEAR_BIT      = 0;
    localparam logic [31:0] RD_RST     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // instruction classes
    typedef enum logic [4:0] {
        CLS_NONE    = 5'b00000,
        CLS_ARITH   = 5'b00001,
        CLS_EXTR    = 5'b00010,
        CLS_EXTR_LU = 5'b00011,
        CLS_SHIFT_S = 5'b00100,
        CLS_SHIFT_D = 5'b00101,
        CLS_FETCH   = 5'b00110,
        CLS_STORE   = 5'b00111,
        CLS_SLJ     = 5'b01000,
        CLS_UJUMP   = 5'b01001,
        CLS_COMP_AM = 5'b01010,
        CLS_COMP_M  = 5'b01011,
        CLS_INDEX   = 5'b01100,
        CLS_VIS_IN  = 5'b01101,
        CLS_VIS_OUT = 5'b01110
    } isc_class_t;

    // chain and operand use of one class
    typedef struct packed {
        logic a_in;
        logic m_in;
        logic res;
        logic opa;
        logic opm;
        logic direct_sel;
        logic shift_lsd;
    } isc_chain_t;

    typedef struct packed {
        logic epd;
        logic stage_four_flag;
        logic stage_three_flag;
        logic stage_two_flag;
        logic stage_one_flag;
    } isc_stage_t;

    typedef struct packed {
        logic                    cycle_start_pulse;
        logic [TP_COUNT-1:0]     timing_pulse;
    } isc_timing_t;

    typedef struct packed {
        logic completing_call;
        logic no_conflict_inequality;
        logic instruction_ending_pulse;
        logic general_clear;
        logic double_first_half;
    } isc_seq_in_t;

    typedef struct packed {
        logic [7:0]          opcode;                 // two decimal digits
        logic [7:0]          m_lsd;                  // two low digits of m
        logic [A_PART_W-1:0] a_part;
        logic                double_precision;
        logic                multiply;
    } isc_instr_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } isc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } isc_apb_rsp_t;

endpackage : isc_pkg

// ===== logic/isc_timing_gen.sv
// free-running cycle phase counter giving cycle start and numbered timing pulses
`timescale 1ns/1ps
`default_nettype none
module isc_timing_gen (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // timing pulses
    output isc_pkg::isc_timing_t tim
);
    import isc_pkg::*;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        isc_timing_t        tim;
    } isc_tg_state_t;

    isc_tg_state_t st_ff;
    isc_tg_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // phase wraps once per cycle; pulses fire on fixed phases
    always_comb begin
        nxt_st = st_ff;
        nxt_st.phase = (st_ff.phase == PHASE_LAST) ? PHASE_RST : st_ff.phase + 1'b1;
        nxt_st.tim.cycle_start_pulse = (nxt_st.phase == PHASE_RST);
        for (int k = 0; k < TP_COUNT; k++) begin
            nxt_st.tim.timing_pulse[k] = (nxt_st.phase == PHASE_W'(k * TP_STEP));
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tim = st_ff.tim;

endmodule // isc_timing_gen
`default_nettype wire

// ===== testbench/isc_properties.sv
// concurrent checks on the stage flags of the status control
`timescale 1ns/1ps
`default_nettype none
module isc_properties (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // watched ports
    input wire isc_pkg::isc_seq_in_t  seq_in,
    input wire isc_pkg::isc_stage_t   stage,
    // register bus, to see a control-register clear
    input wire isc_pkg::isc_apb_req_t apb_req,
    input wire isc_pkg::isc_apb_rsp_t apb_rsp
);
    import isc_pkg::*;
    logic [9:0] ne_ff;
    logic [9:0] n3_ff;
    logic       sclr_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // length of the delay window and of the execute flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ne_ff <= 10'h000;
            n3_ff <= 10'h000;
            sclr_ff <= 1'b0;
        end else begin
            ne_ff <= (stage.epd && !seq_in.instruction_ending_pulse) ? ne_ff + 10'h001 : 10'h000;
            n3_ff <= stage.stage_three_flag ? n3_ff + 10'h001 : 10'h000;
            // a control-register clear acts one cycle after its access edge
            sclr_ff <= apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
                       apb_req.paddr == REG_CTRL && apb_req.pwdata[CTRL_CLEAR_BIT];
        end
    end
    clear_all_a: assert property ((seq_in.general_clear || sclr_ff) |=> stage[3:0] == 4'h0)
        else $error("flags kept");
    delay_start_a: assert property (seq_in.instruction_ending_pulse && !seq_in.general_clear && !sclr_ff
        |=> stage.epd) else $error("delay missing");
    delay_len_a: assert property ($fell(stage.epd) && !$past(seq_in.general_clear) && !$past(sclr_ff)
        |-> $past(ne_ff) == 10'h31f) else $error("delay length");
    one_set_a: assert property ($rose(stage.stage_one_flag) |-> $past(seq_in.completing_call))
        else $error("stage one set");
    two_set_a: assert property ($rose(stage.stage_two_flag) |-> $past(stage.stage_one_flag)
        && $past(seq_in.no_conflict_inequality)) else $error("stage two set");
    two_clr_a: assert property ($fell(stage.stage_two_flag) && !$past(seq_in.general_clear)
        && !$past(sclr_ff) |-> $past(stage.epd)) else $error("stage two clear");
    three_len_a: assert property ($fell(stage.stage_three_flag) && !$past(seq_in.general_clear)
        && !$past(sclr_ff) |-> $past(n3_ff) == 10'h31f && !stage.epd) else $error("stage three length");
    four_set_a: assert property ($rose(stage.stage_four_flag) |-> $past(stage.stage_three_flag)
        && !$past(seq_in.double_first_half)) else $error("stage four set");
endmodule // isc_properties
`default_nettype wire

// ===== testbench/isc_au_model.sv
// arithmetic unit stand-in: ends the instruction a set time into operand select
`timescale 1ns/1ps
`default_nettype none
module isc_au_model #(
    parameter int DELAY = 900
) (
    // clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // stage flags in, ending pulse out
    input wire isc_pkg::isc_stage_t stage,
    output logic                   end_pulse
);
    import isc_pkg::*;
    int cnt_ff;
    // one pulse per operand select interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_ff <= 0;
        else cnt_ff <= stage.stage_two_flag ? cnt_ff + 1 : 0;
    end
    assign end_pulse = (cnt_ff == DELAY);
endmodule // isc_au_model
`default_nettype wire

// ===== testbench/instruction_stage_status_control_test.sv
// bench stepping instructions through the stage chain and reading registers
`timescale 1ns/1ps
`default_nettype none
module instruction_stage_status_control_test;
    import isc_pkg::*;
    logic pclk, presetn, call, nc, gc, dfh, epl, err;
    logic [31:0] rd;
    logic [7:0] ash;
    logic [19:0] fsel;
    int fail_count = 0, n_tests = 0, cyc = 0;
    isc_apb_req_t req;
    isc_apb_rsp_t rsp;
    isc_instr_t ins;
    isc_stage_t stage;
    isc_status_ctrl uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .seq_in({call, nc, epl, gc, dfh}), .second_instr(ins), .stage(stage), .chain_use(), .a_input_uses(),
        .result_uses(), .mem_refs(), .control_group(), .arith_group(), .program_stage_line(),
        .shift_digits_transfer(), .arith_shift_register(ash), .selector_direct_load(), .fast_reg_selector(fsel));
    isc_au_model au (.pclk(pclk), .presetn(presetn), .stage(stage), .end_pulse(epl));
    // clock and hang limit
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk); // idle cycle, so a following call never re-drives req in the same step
    endtask
    // one instruction from call to result, checked once per cycle
    task automatic run(input logic [7:0] op, input logic dh, input logic [13:0] ch);
        logic [4:0] ex [6];
        logic [7:0] m;
        logic [19:0] a;
        ex = '{5'h01, 5'h02, 5'h12, 5'h04, dh ? 5'h00 : 5'h08, 5'h00};
        m = ~op;
        a = {op, op, 4'h5};
        ins <= '{op, m, a, 1'b0, 1'b0};
        dfh <= dh;
        call <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            repeat (798) @(posedge pclk);
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            call <= 1'b0;
            chk("stage", ex[i], stage);
            chk("status", ex[i], rd[4:0]);
            if (i == 1) apb(1'b0, REG_CHAIN, 32'h0000_0000);
            if (i == 1) chk("chain", ch, rd[13:0]);
        end
        if (ch[0]) chk("shift digits", m, ash);
        if (ch[1]) chk("selector", a, fsel);
        apb(1'b0, REG_OPSEL, 32'h0000_0000);
        chk("opsel", 32'h0000_0640, rd);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        {presetn, call, gc, dfh} = 4'h0;
        nc = 1'b1;
        req = '0;
        ins = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (400) @(posedge pclk);
        run(8'h51, 1'b0, 14'h043B);
        run(8'h70, 1'b1, 14'h00EA);
        run(8'h65, 1'b0, 14'h14FC);
        run(8'h90, 1'b0, 14'h0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, err);
        // conflict: stage one holds and stage two stays clear
        call <= 1'b1;
        nc <= 1'b0;
        repeat (800) @(posedge pclk);
        call <= 1'b0;
        repeat (800) @(posedge pclk);
        chk("conflict hold", 32'h0000_0001, stage);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("soft clear", 32'h0000_0000, stage);
        call <= 1'b1;
        repeat (800) @(posedge pclk);
        gc <= 1'b1;
        call <= 1'b0;
        @(posedge pclk);
        gc <= 1'b0;
        @(posedge pclk);
        chk("port clear", 32'h0000_0000, stage);
        stop_test();
    end
endmodule // instruction_stage_status_control_test
bind isc_status_ctrl isc_properties props (.pclk(pclk), .presetn(presetn), .seq_in(seq_in), .stage(stage),
    .apb_req(apb_req), .apb_rsp(apb_rsp));
`default_nettype wire
